// File: rtl/cpi_pkg.sv
// package: opcode fields, cache geometry, register offsets and carrier types
package cpi_pkg;
   localparam int ADDR_W = 32;
   localparam int LINE_LSB = 4;
   localparam int PAGE4K_LSB = 12;
   localparam int PAGE8K_LSB = 13;
   localparam logic [7:0] OPC_HI = 8'hf4;
   localparam int OPC_PUSH_BIT = 5;
   localparam int CACHE_MSB = 7;
   localparam int CACHE_LSB = 6;
   localparam int SCOPE_MSB = 4;
   localparam int SCOPE_LSB = 3;
   localparam int REG_MSB = 2;
   localparam logic [1:0] CACHE_NONE = 2'h0;
   localparam logic [1:0] SCOPE_ILLEGAL = 2'h0;
   localparam logic [1:0] SCOPE_LINE = 2'h1;
   localparam logic [1:0] SCOPE_PAGE = 2'h2;
   localparam logic [1:0] SCOPE_ALL = 2'h3;
   // register map (word offsets in bytes)
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STAT = 4'h4;
   localparam logic [3:0] OFF_MASK = 4'h8;
   localparam logic [3:0] OFF_STATE = 4'hc;
   localparam int EV_DONE = 0;
   localparam int EV_PRIV = 1;
   localparam int EV_ILL = 2;
   localparam int EV_W = 3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [2:0] EV_RST = 3'h0;

   typedef struct packed {
      logic [1:0] cache;
      logic [1:0] scope;
      logic [2:0] areg;
   } op_fields_t;

   typedef struct packed {
      logic valid;
      logic dirty;
      logic [ADDR_W-1:LINE_LSB] tag;
   } line_t;
endpackage

// File: rtl/line_mem.sv
// small cache-line store, registered read data
`timescale 1ns/1ps
module line_mem #(
   parameter int DEPTH = 16,
   parameter int AW = 4
)(
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire cpi_pkg::line_t wdata,
   // read port
   input wire logic [AW-1:0] raddr,
   output cpi_pkg::line_t rdata
);
   cpi_pkg::line_t mem [DEPTH];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule

// File: rtl/cache_push_invalidate_ctrl.sv
// push/invalidate controller for data and instruction line stores
`timescale 1ns/1ps
// What this block does
// - only in supervisor state, else privilege trap
// - dirty data lines written back, then invalidated
// - instruction lines invalidated without write-back
// - cache field 00 none, 01 D, 10 I, 11 both
// - scope 01 line, 10 page, 11 all
// - scope 00 illegal trap, caches untouched
// - register field picks the address register
// - line scope matches tag of register address
// - page scope matches every line in page
// - all scope takes every entry, no address
// - line match ignores address bits 3-0
// - page match ignores 11-0 or 12-0
module cache_push_invalidate_ctrl #(
   parameter int LINES = 16,
   parameter int IDX_W = 4
)(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // instruction from execution unit
   input wire logic op_valid,
   input wire logic [15:0] opcode,
   input wire logic supervisor,
   input wire logic [31:0] areg_file [8],
   // completion
   output logic op_done,
   output logic priv_trap,
   output logic illegal_trap,
   output logic ccr_write,
   // push to memory
   output logic push_valid,
   output logic [31:0] push_addr,
   input wire logic push_ack,
   // fill from the cache datapath
   input wire logic fill_valid,
   input wire logic fill_icache,
   input wire logic fill_dirty,
   input wire logic [31:0] fill_addr,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum {ST_IDLE, ST_READ, ST_CHECK, ST_PUSH, ST_INV, ST_NEXT, ST_FIN} state_t;

   logic [1:0] rst_sync_r;
   logic rst_n;
   state_t state_r;
   cpi_pkg::op_fields_t op_r;
   logic [31:0] addr_r;
   logic [IDX_W-1:0] idx_r;
   logic icache_r;
   logic page8k_r;
   logic [cpi_pkg::EV_W-1:0] stat_r, mask_r;
   logic [31:0] ctrl_r;
   cpi_pkg::line_t d_rd, i_rd, cur, wline;
   logic d_we, i_we;
   logic [IDX_W-1:0] d_waddr, i_waddr;
   logic [cpi_pkg::EV_W-1:0] ev;
   logic opc_hit;
   logic [LINES-1:0] d_vld_r, i_vld_r;
   logic cur_vld;

   assign page8k_r = ctrl_r[0];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_sync_r <= 2'h0;
      end
      else
      begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // address bits below lsb are don't-care for a match
   function automatic logic [31:0] keep_mask(input int lsb);
      keep_mask = 32'hffff_ffff << lsb;
   endfunction

   // byte address of the first byte of a stored line
   function automatic logic [31:0] line_base(input cpi_pkg::line_t l);
      line_base = {l.tag, {cpi_pkg::LINE_LSB{1'b0}}};
   endfunction

   // match: mask off the don't-care low bits for the chosen scope
   function automatic logic hit(input logic [1:0] scope, input logic [31:0] a,
                                input logic [31:0] t, input logic p8);
      logic [31:0] m;
      m = keep_mask(cpi_pkg::LINE_LSB);
      if (scope == cpi_pkg::SCOPE_PAGE)
      begin
         m = p8 ? keep_mask(cpi_pkg::PAGE8K_LSB) : keep_mask(cpi_pkg::PAGE4K_LSB);
      end
      hit = (scope == cpi_pkg::SCOPE_ALL) || ((a & m) == (t & m));
   endfunction

   assign opc_hit = (opcode[15:8] == cpi_pkg::OPC_HI) && opcode[cpi_pkg::OPC_PUSH_BIT];
   assign cur = icache_r ? i_rd : d_rd;

   ////////////////////////////////////////////////////////////////////////////
   // line stores; fills come from the datapath while the walker is idle
   always_comb
   begin
      wline = '0;
      d_we = 1'b0;
      i_we = 1'b0;
      d_waddr = idx_r;
      i_waddr = idx_r;
      if (state_r == ST_INV)
      begin
         d_we = !icache_r;
         i_we = icache_r;
      end
      else if (fill_valid && state_r == ST_IDLE)
      begin
         wline.valid = 1'b1;
         wline.dirty = fill_dirty && !fill_icache;
         wline.tag = fill_addr[31:cpi_pkg::LINE_LSB];
         d_waddr = fill_addr[cpi_pkg::LINE_LSB +: IDX_W];
         i_waddr = d_waddr;
         d_we = !fill_icache;
         i_we = fill_icache;
      end
   end

   line_mem #(.DEPTH(LINES), .AW(IDX_W)) u_dmem (
      .clk(clk), .we(d_we), .waddr(d_waddr), .wdata(wline), .raddr(idx_r), .rdata(d_rd)
   );
   line_mem #(.DEPTH(LINES), .AW(IDX_W)) u_imem (
      .clk(clk), .we(i_we), .waddr(i_waddr), .wdata(wline), .raddr(idx_r), .rdata(i_rd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // valid bits live in flops so every line reads invalid out of reset;
   // the stores have no reset and may power up holding anything
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         d_vld_r <= '0;
      end
      else if (d_we)
      begin
         d_vld_r[d_waddr] <= wline.valid;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         i_vld_r <= '0;
      end
      else if (i_we)
      begin
         i_vld_r[i_waddr] <= wline.valid;
      end
   end

   assign cur_vld = icache_r ? i_vld_r[idx_r] : d_vld_r[idx_r];

   ////////////////////////////////////////////////////////////////////////////
   // walker: every index of each selected cache, data first
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         op_r <= '0;
         addr_r <= 32'h0000_0000;
         idx_r <= '0;
         icache_r <= 1'b0;
         op_done <= 1'b0;
         priv_trap <= 1'b0;
         illegal_trap <= 1'b0;
         push_valid <= 1'b0;
         push_addr <= 32'h0000_0000;
      end
      else
      begin
         op_done <= 1'b0;
         priv_trap <= 1'b0;
         illegal_trap <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            begin
               idx_r <= '0;
               if (op_valid && opc_hit)
               begin
                  op_r <= '{opcode[7:6], opcode[4:3], opcode[2:0]};
                  addr_r <= areg_file[opcode[cpi_pkg::REG_MSB:0]];
                  icache_r <= !opcode[cpi_pkg::CACHE_LSB];
                  if (!supervisor)
                  begin
                     priv_trap <= 1'b1;
                  end
                  else if (opcode[4:3] == cpi_pkg::SCOPE_ILLEGAL)
                  begin
                     illegal_trap <= 1'b1;
                  end
                  else if (opcode[7:6] == cpi_pkg::CACHE_NONE)
                  begin
                     op_done <= 1'b1;
                  end
                  else
                  begin
                     state_r <= ST_READ;
                  end
               end
            end
            ST_READ: state_r <= ST_CHECK;
            ST_CHECK:
            begin
               if (cur_vld && hit(op_r.scope, addr_r, line_base(cur), page8k_r))
               begin
                  if (!icache_r && cur.dirty)
                  begin
                     push_valid <= 1'b1;
                     push_addr <= line_base(cur);
                     state_r <= ST_PUSH;
                  end
                  else
                  begin
                     state_r <= ST_INV;
                  end
               end
               else
               begin
                  state_r <= ST_NEXT;
               end
            end
            ST_PUSH:
            begin
               if (push_ack)
               begin
                  push_valid <= 1'b0;
                  state_r <= ST_INV;
               end
            end
            ST_INV: state_r <= ST_NEXT;
            ST_NEXT:
            begin
               idx_r <= idx_r + 1'b1;
               state_r <= ST_READ;
               if (idx_r == IDX_W'(LINES - 1))
               begin
                  idx_r <= '0;
                  // both caches: data pass then instruction pass
                  if (!icache_r && op_r.cache[1])
                  begin
                     icache_r <= 1'b1;
                  end
                  else
                  begin
                     state_r <= ST_FIN;
                  end
               end
            end
            ST_FIN:
            begin
               op_done <= 1'b1;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // condition codes are never written by this operation
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ccr_write <= 1'b0;
      end
      else
      begin
         ccr_write <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and interrupt; set beats write-one-clear
   assign ev = {illegal_trap, priv_trap, op_done};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= cpi_pkg::CTRL_RST;
         mask_r <= cpi_pkg::EV_RST;
         stat_r <= cpi_pkg::EV_RST;
      end
      else
      begin
         if (reg_wr && reg_addr == cpi_pkg::OFF_CTRL)
         begin
            ctrl_r <= 32'(reg_wdata[0]);
         end
         if (reg_wr && reg_addr == cpi_pkg::OFF_MASK)
         begin
            mask_r <= reg_wdata[cpi_pkg::EV_W-1:0];
         end
         if (reg_wr && reg_addr == cpi_pkg::OFF_STAT)
         begin
            stat_r <= (stat_r & ~reg_wdata[cpi_pkg::EV_W-1:0]) | ev;
         end
         else
         begin
            stat_r <= stat_r | ev;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(stat_r & mask_r);
         reg_rdata <= 32'h0000_0000;
         if (reg_rd)
         begin
            unique case (reg_addr)
               cpi_pkg::OFF_CTRL: reg_rdata <= ctrl_r;
               cpi_pkg::OFF_STAT: reg_rdata <= 32'(stat_r);
               cpi_pkg::OFF_MASK: reg_rdata <= 32'(mask_r);
               cpi_pkg::OFF_STATE: reg_rdata <= 32'({push_valid, idx_r});
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// File: verif/cpi_monitor.sv
// checker for the push/invalidate controller ports
`timescale 1ns/1ps
module cpi_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // operation
   input wire logic op_valid,
   input wire logic [15:0] opcode,
   input wire logic supervisor,
   input wire logic op_done,
   input wire logic priv_trap,
   input wire logic illegal_trap,
   input wire logic ccr_write,
   // push
   input wire logic push_valid,
   input wire logic [31:0] push_addr,
   input wire logic push_ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ops only arrive while idle, so no busy tracking here
   logic hit;
   logic sup_ok;
   assign hit = op_valid && opcode[15:8] == cpi_pkg::OPC_HI && opcode[cpi_pkg::OPC_PUSH_BIT];
   assign sup_ok = hit && supervisor && opcode[4:3] != 2'h0;
   sequence s_user;
      hit && !supervisor;
   endsequence
   sequence s_ill;
      hit && supervisor && opcode[4:3] == 2'h0;
   endsequence
   sequence s_quiet;
      !push_valid [*8];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   priv_trap_a: assert property (s_user |=> (priv_trap && !op_done) ##0 s_quiet)
      else $error("user op gave no trap or pushed");
   ill_trap_a: assert property (s_ill |=> (illegal_trap && !op_done) ##0 s_quiet)
      else $error("scope 00 gave no trap or pushed");
   none_done_a: assert property (sup_ok && opcode[7:6] == 2'h0 |=> op_done)
      else $error("cache 00 did not finish at once");
   inst_quiet_a: assert property (sup_ok && opcode[7:6] == 2'h2 |=> s_quiet)
      else $error("instruction cache op pushed");
   unrec_quiet_a: assert property (op_valid && !hit |=> !(op_done || priv_trap || illegal_trap))
      else $error("unrecognised opcode answered");
   push_hold_a: assert property (push_valid && !push_ack |=> push_valid && $stable(push_addr))
      else $error("push dropped before ack");
   push_line_a: assert property (push_valid |-> push_addr[3:0] == 4'h0)
      else $error("push address not line aligned");
   done_after_a: assert property (op_done |-> !push_valid && !$past(push_valid))
      else $error("done while push outstanding");
   flags_kept_a: assert property (!ccr_write)
      else $error("condition flags written");
endmodule
bind cache_push_invalidate_ctrl cpi_monitor u_mon (.clk, .nrst, .op_valid, .opcode, .supervisor,
   .op_done, .priv_trap, .illegal_trap, .ccr_write, .push_valid, .push_addr, .push_ack);

// File: verif/push_mem_model.sv
// memory side: accepts pushed lines, promptly or after a wait
`timescale 1ns/1ps
module push_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // push
   input wire logic push_valid,
   input wire logic [31:0] push_addr,
   output logic push_ack,
   // pacing
   input wire logic slow
);
   logic [31:0] q [$];
   logic [1:0] wt;
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         push_ack <= 1'b0;
         wt <= 2'h0;
      end
      else
      begin
         // slow mode holds the line off three cycles
         push_ack <= push_valid && !push_ack && (wt == 2'h3 || !slow);
         wt <= (push_valid && !push_ack) ? wt + 2'h1 : 2'h0;
         if (push_valid && push_ack) q.push_back(push_addr);
      end
   end
endmodule

// File: verif/cache_push_invalidate_ctrl_bench.sv
// bench: fills lines, issues push/invalidate ops, checks pushes and registers
`timescale 1ns/1ps
module cache_push_invalidate_ctrl_bench;
   logic clk, nrst, op_valid, supervisor, fill_valid, fill_icache, fill_dirty, reg_wr, reg_rd;
   logic slow, op_done, priv_trap, illegal_trap, ccr_write, push_valid, push_ack, irq;
   logic [15:0] opcode;
   logic [31:0] areg [8];
   logic [31:0] fill_addr, reg_wdata, push_addr, reg_rdata;
   logic [3:0] reg_addr;
   logic [2:0] ev;
   int err_count = 0;
   int compares = 0;
   cache_push_invalidate_ctrl u_dut (.clk, .nrst, .op_valid, .opcode, .supervisor,
      .areg_file(areg), .op_done, .priv_trap, .illegal_trap, .ccr_write, .push_valid, .push_addr,
      .push_ack, .fill_valid, .fill_icache, .fill_dirty, .fill_addr, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .irq);
   push_mem_model u_mem (.clk, .nrst, .push_valid, .push_addr, .push_ack, .slow);
   ////////////////////////////////////////////////////////////////////////////
   task finish_test;
      if (err_count == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(logic [3:0] a, logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic fill(logic ic, logic dt, logic [31:0] a);
      @(posedge clk);
      fill_valid <= 1'b1;
      fill_icache <= ic;
      fill_dirty <= dt;
      fill_addr <= a;
      @(posedge clk);
      fill_valid <= 1'b0;
   endtask
   // op, then expected {illegal,priv,done}, push count and first pushed address
   task automatic op(logic [1:0] c, logic [1:0] s, logic [2:0] r, logic sup, logic [2:0] e,
         int n, logic [31:0] a);
      ev = 3'h0;
      @(posedge clk);
      op_valid <= 1'b1;
      opcode <= {cpi_pkg::OPC_HI, c, 1'b1, s, r};
      supervisor <= sup;
      @(posedge clk);
      op_valid <= 1'b0;
      for (int i = 0; i < 400 && ev === 3'h0; i++)
      begin
         #1 ev = {illegal_trap, priv_trap, op_done};
         if (ev === 3'h0) @(posedge clk);
      end
      chk("event", {29'h0, e}, {29'h0, ev});
      chk("push_count", n, u_mem.q.size());
      if (n > 0) chk("push_addr", a, u_mem.q[0]);
      u_mem.q.delete();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      #40000;
      err_count++;
      finish_test;
   end
   initial
   begin
      {op_valid, supervisor, fill_valid, fill_icache, fill_dirty, reg_wr, reg_rd, slow} = 8'h00;
      {opcode, fill_addr, reg_wdata, reg_addr} = '0;
      nrst = 1'b0;
      // reg 0 points at another dirty line, so a wrong register pick shows
      areg = '{32'h5555_0050, 32'h1234_501c, 32'h1234_5fff, 0, 0, 0, 0, 0};
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(cpi_pkg::OFF_CTRL, cpi_pkg::CTRL_RST);
      rdc(cpi_pkg::OFF_MASK, 32'h0000_0000);
      fill(1'b0, 1'b1, 32'h1234_5010);
      fill(1'b0, 1'b1, 32'h1234_5a20);
      fill(1'b0, 1'b0, 32'h1234_5030);
      fill(1'b0, 1'b1, 32'h1234_4040);
      fill(1'b0, 1'b1, 32'h5555_0050);
      fill(1'b1, 1'b1, 32'h1234_5060);
      op(2'h1, 2'h1, 3'h1, 1'b0, 3'h2, 0, 0);
      op(2'h1, 2'h0, 3'h1, 1'b1, 3'h4, 0, 0);
      op(2'h0, 2'h1, 3'h1, 1'b1, 3'h1, 0, 0);
      @(posedge clk);
      op_valid <= 1'b1;
      opcode <= 16'hf408;
      @(posedge clk);
      op_valid <= 1'b0;
      rdc(cpi_pkg::OFF_STAT, 32'h0000_0007);
      chk("irq", 32'h0, {31'h0, irq});
      wr(cpi_pkg::OFF_MASK, 32'h0000_0002);
      repeat (2) @(posedge clk);
      #1 chk("irq", 32'h1, {31'h0, irq});
      wr(cpi_pkg::OFF_STAT, 32'h0000_0002);
      repeat (2) @(posedge clk);
      #1 chk("irq", 32'h0, {31'h0, irq});
      rdc(cpi_pkg::OFF_STAT, 32'h0000_0005);
      rdc(4'h1, 32'h0000_0000);
      rdc(cpi_pkg::OFF_STATE, 32'h0000_0000);
      op(2'h1, 2'h1, 3'h1, 1'b1, 3'h1, 1, 32'h1234_5010);
      op(2'h1, 2'h1, 3'h1, 1'b1, 3'h1, 0, 0);
      slow <= 1'b1;
      op(2'h1, 2'h2, 3'h2, 1'b1, 3'h1, 1, 32'h1234_5a20);
      wr(cpi_pkg::OFF_CTRL, 32'h0000_0001);
      rdc(cpi_pkg::OFF_CTRL, 32'h0000_0001);
      op(2'h1, 2'h2, 3'h2, 1'b1, 3'h1, 1, 32'h1234_4040);
      op(2'h2, 2'h3, 3'h0, 1'b1, 3'h1, 0, 0);
      op(2'h3, 2'h3, 3'h0, 1'b1, 3'h1, 1, 32'h5555_0050);
      finish_test;
   end
endmodule
